/* hdl/srwr_defines.svh */
`ifndef SRWR_DEFINES_SVH
`define SRWR_DEFINES_SVH
// write command codes
`define SRWR_CMD_AUTO 8'h02
`define SRWR_CMD_CONF 8'h05
`define SRWR_CMD_BCAST 8'h08
// address windows
`define SRWR_AUTO_LAST 16'hFFDD
`define SRWR_CONF_FIRST 16'h03E9
`define SRWR_CONF_LAST 16'h040C
// length window in bytes
`define SRWR_LEN_MIN 3'h1
`define SRWR_LEN_MAX 3'h4
// application-layer control offset
`define SRWR_ALCTL_OFS 16'h0120
// error codes
`define SRWR_ERR_NOSLAVE 16'h0F09
`define SRWR_ERR_ADDR 16'h0F70
`define SRWR_ERR_LEN 16'h0F71
`define SRWR_ERR_CMD 16'h0F72
`define SRWR_ERR_NORESP 16'h0F73
`define SRWR_ERR_OFS 16'h0F74
`define SRWR_ERR_PREEMPT 16'h1021
// response timeout: time in us and derived count at 200 MHz
`define SRWR_RESP_TIMEOUT_US 32'h0000_0064
`define SRWR_CLK_MHZ 32'h0000_00C8
`define SRWR_RESP_CYCLES (`SRWR_RESP_TIMEOUT_US * `SRWR_CLK_MHZ)
// register offsets
`define SRWR_REG_STATUS 4'h0
`define SRWR_REG_MASK 4'h4
`define SRWR_REG_LASTWKC 4'h8
`define SRWR_STAT_W 3
`endif

/* hdl/srwr_pkg.sv */
package srwr_pkg;
  // request sequencer states
  typedef enum logic [2:0]
  {
    SRWR_IDLE,
    SRWR_SEND,
    SRWR_WAIT,
    SRWR_DONE,
    SRWR_FAIL
  } srwr_state_type;

  // all state of the request unit
  typedef struct packed
  {
    srwr_state_type state;
    logic execPrev;
    logic [15:0] posAddr;
    logic [15:0] regOfs;
    logic [2:0] byteLen;
    logic [7:0] cmdCode;
    logic [31:0] wrValue;
    logic [15:0] workCount;
    logic [15:0] errorId;
    logic [14:0] waitCnt;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    logic [31:0] rdData;
  } srwr_regs_type;
endpackage

/* hdl/slave_register_write_request.sv */
`include "srwr_defines.svh"

// Operation
// (R01) accept only write codes 2, 5, 8
// (R02) broadcast ignores position address input
// (R03) auto-increment address 0x0000 down to 0xFFDD
// (R04) configured address lies in 1001..1036
// (R05) bad position address aborts with 0x0F70
// (R06) bad byte length aborts with 0x0F71
// (R07) unknown command code aborts with 0x0F72
// (R08) no slave attached refuses with 0x0F09
// (R09) no network response reports 0x0F73
// (R10) protected offsets refused with 0x0F74
// (R11) AL control allowed once communication normal; the code also requires connBusy low
// (R12) working counter zero at start, final at done
// (R13) each successful slave adds one to counter
// (R14) done only after slave wrote normally
// (R15) later read request preempts this write, 0x1021
// (R16) slave control registers 0x0000-0x0FFF, memory above
// (R17) start on execute edge, busy, 1-4 bytes
module slave_register_write_request
  import srwr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  // user request side
  input wire logic execute,
  input wire logic [7:0] writeCommandCode,
  input wire logic [15:0] positionAddr,
  input wire logic [15:0] regOffset,
  input wire logic [2:0] byteLength,
  input wire logic [31:0] writeValue,
  input wire logic readStart,
  output logic busy,
  output logic done,
  output logic error,
  output logic [15:0] errorId,
  output logic [15:0] workCount,
  // network status
  input wire logic slavePresent,
  input wire logic commNormal,
  input wire logic connBusy,
  // datagram issue toward the network
  output logic dgValid,
  input wire logic dgReady,
  output logic [7:0] dgCmd,
  output logic [15:0] dgAddr,
  output logic [15:0] dgOffset,
  output logic [2:0] dgLength,
  output logic [31:0] dgData,
  input wire logic rspValid,
  input wire logic [15:0] rspWkc,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic irq
);

  // ****************************************
  // helper functions
  // ****************************************

  // offset falls in a protected slave register range
  function automatic logic ofsProtected(input logic [15:0] ofs, input logic alOk);
    logic hit;
    hit = 1'b0;
    if (ofs == 16'h0010 || ofs == 16'h0011)
    begin
      hit = 1'b1;
    end
    if (ofs == 16'h0020 || ofs == 16'h0021 || ofs == 16'h0030 || ofs == 16'h0031)
    begin
      hit = 1'b1;
    end
    if (ofs == 16'h0040 || (ofs >= 16'h0100 && ofs <= 16'h0103))
    begin
      hit = 1'b1;
    end
    // al control low byte is freed once the link runs normally and the connection is not busy
    if (ofs == `SRWR_ALCTL_OFS)
    begin
      hit = !alOk; // see (R11)
    end
    if (ofs == 16'h0121)
    begin
      hit = 1'b1;
    end
    if ((ofs >= 16'h0600 && ofs <= 16'h06FF) || (ofs >= 16'h0800 && ofs <= 16'h087F))
    begin
      hit = 1'b1;
    end
    if (ofs >= 16'h0900 && ofs <= 16'h09FF)
    begin
      hit = 1'b1;
    end
    return hit; // see (R10)
  endfunction

  // position address allowed for the given command
  function automatic logic addrOk(input logic [7:0] cmd, input logic [15:0] adr);
    logic ok;
    ok = 1'b0;
    case (cmd)
      `SRWR_CMD_AUTO: ok = (adr == 16'h0000) || (adr >= `SRWR_AUTO_LAST); // see (R03)
      `SRWR_CMD_CONF: ok = (adr >= `SRWR_CONF_FIRST) && (adr <= `SRWR_CONF_LAST); // see (R04)
      `SRWR_CMD_BCAST: ok = 1'b1; // see (R02)
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ****************************************
  // state
  // ****************************************

  srwr_regs_type r_ff; // registered state
  srwr_regs_type nxt_r; // next state
  logic execRise; // start request
  logic cmdOk; // command is a write code
  logic regWkcWr; // write-one-to-clear strobe for the status register

  assign execRise = execute && !r_ff.execPrev;
  assign cmdOk = (writeCommandCode == `SRWR_CMD_AUTO) || (writeCommandCode == `SRWR_CMD_CONF)
                 || (writeCommandCode == `SRWR_CMD_BCAST); // see (R01)
  assign regWkcWr = regWr && (regAddr == `SRWR_REG_STATUS);

  // ****************************************
  // next-state logic
  // ****************************************

  // sequencer, event capture and register port in one process
  always_comb
  begin
    logic [2:0] ev;
    ev = 3'h0;
    nxt_r = r_ff;
    nxt_r.execPrev = execute;
    nxt_r.rdData = 32'h0;
    case (r_ff.state)
      SRWR_IDLE:
      begin
        // checks run in priority order: slave presence, command, address, length, offset
        if (execRise) // see (R17)
        begin
          nxt_r.workCount = 16'h0; // see (R12)
          nxt_r.errorId = 16'h0;
          nxt_r.cmdCode = writeCommandCode;
          nxt_r.posAddr = (writeCommandCode == `SRWR_CMD_BCAST) ? 16'h0 : positionAddr; // see (R02)
          nxt_r.regOfs = regOffset;
          nxt_r.byteLen = byteLength;
          nxt_r.wrValue = writeValue;
          nxt_r.state = SRWR_FAIL;
          if (!slavePresent)
          begin
            nxt_r.errorId = `SRWR_ERR_NOSLAVE; // see (R08)
          end
          else if (!cmdOk)
          begin
            nxt_r.errorId = `SRWR_ERR_CMD; // see (R07)
          end
          else if (!addrOk(writeCommandCode, positionAddr))
          begin
            nxt_r.errorId = `SRWR_ERR_ADDR; // see (R05)
          end
          else if (byteLength < `SRWR_LEN_MIN || byteLength > `SRWR_LEN_MAX)
          begin
            nxt_r.errorId = `SRWR_ERR_LEN; // see (R06)
          end
          else if (ofsProtected(regOffset, commNormal && !connBusy))
          begin
            nxt_r.errorId = `SRWR_ERR_OFS; // see (R10)
          end
          else
          begin
            nxt_r.state = SRWR_SEND;
          end
        end
      end
      SRWR_SEND:
      begin
        // hold the datagram until the network side takes it
        if (readStart)
        begin
          nxt_r.errorId = `SRWR_ERR_PREEMPT; // see (R15)
          nxt_r.state = SRWR_FAIL;
        end
        else if (dgReady)
        begin
          nxt_r.waitCnt = 15'h0;
          nxt_r.state = SRWR_WAIT;
        end
      end
      SRWR_WAIT:
      begin
        nxt_r.waitCnt = r_ff.waitCnt + 15'h1;
        if (readStart)
        begin
          nxt_r.errorId = `SRWR_ERR_PREEMPT; // see (R15)
          nxt_r.state = SRWR_FAIL;
        end
        else if (rspValid)
        begin
          // zero counter means the addressed slave did not write
          if (rspWkc != 16'h0) // see (R13)
          begin
            nxt_r.workCount = rspWkc; // see (R12)
            nxt_r.state = SRWR_DONE; // see (R14)
          end
          else
          begin
            nxt_r.errorId = `SRWR_ERR_NORESP; // see (R09)
            nxt_r.state = SRWR_FAIL;
          end
        end
        else if (r_ff.waitCnt == 15'(`SRWR_RESP_CYCLES - 32'h1))
        begin
          nxt_r.errorId = `SRWR_ERR_NORESP; // see (R09)
          nxt_r.state = SRWR_FAIL;
        end
      end
      SRWR_DONE:
      begin
        ev[0] = 1'b1;
        nxt_r.state = SRWR_IDLE;
      end
      SRWR_FAIL:
      begin
        ev[1] = 1'b1;
        ev[2] = (r_ff.errorId == `SRWR_ERR_PREEMPT);
        nxt_r.state = SRWR_IDLE;
      end
      default:
      begin
        nxt_r.state = SRWR_IDLE;
      end
    endcase
    // sticky status: a new event wins over a write-one clear
    if (regWkcWr)
    begin
      nxt_r.irqStat = r_ff.irqStat & ~regWdata[`SRWR_STAT_W-1:0];
    end
    nxt_r.irqStat = nxt_r.irqStat | ev;
    if (regWr && regAddr == `SRWR_REG_MASK)
    begin
      nxt_r.irqMask = regWdata[`SRWR_STAT_W-1:0];
    end
    // read data stands the cycle after the strobe only
    if (regRd)
    begin
      case (regAddr)
        `SRWR_REG_STATUS: nxt_r.rdData = {29'h0, r_ff.irqStat};
        `SRWR_REG_MASK: nxt_r.rdData = {29'h0, r_ff.irqMask};
        `SRWR_REG_LASTWKC: nxt_r.rdData = {r_ff.errorId, r_ff.workCount};
        default: nxt_r.rdData = 32'h0;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************

  // synchronous reset to idle
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      r_ff <= '{state: SRWR_IDLE, default: '0};
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************

  // done and error pulse for one cycle; busy covers the whole exchange
  assign busy = (r_ff.state == SRWR_SEND) || (r_ff.state == SRWR_WAIT); // see (R17)
  assign done = (r_ff.state == SRWR_DONE);
  assign error = (r_ff.state == SRWR_FAIL);
  assign errorId = r_ff.errorId;
  assign workCount = r_ff.workCount;
  assign dgValid = (r_ff.state == SRWR_SEND);
  assign dgCmd = r_ff.cmdCode;
  assign dgAddr = r_ff.posAddr;
  assign dgOffset = r_ff.regOfs;
  assign dgLength = r_ff.byteLen;
  assign dgData = r_ff.wrValue;
  assign regRdata = r_ff.rdData;
  assign irq = |(r_ff.irqStat & r_ff.irqMask);

  // ****************************************
  // assertions
  // ****************************************

  a_bad_cmd_err: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R07)
    (r_ff.state == SRWR_IDLE && execRise && slavePresent && !cmdOk) |=> error
    && errorId == `SRWR_ERR_CMD) else $error("bad command not refused");
  a_noslave_err: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R08)
    (r_ff.state == SRWR_IDLE && execRise && !slavePresent) |=> error
    && errorId == `SRWR_ERR_NOSLAVE) else $error("missing slave not refused");
  a_len_err: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R06)
    (error && errorId == `SRWR_ERR_LEN) |-> $past(byteLength) == 3'h0
    || $past(byteLength) > 3'h4) else $error("length error without cause");
  a_prot_nosend: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R10)
    (r_ff.state == SRWR_IDLE && execRise && slavePresent && cmdOk
    && regOffset >= 16'h0800 && regOffset <= 16'h087F) |=> !dgValid)
    else $error("protected offset sent");
  a_wkc_start: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R12)
    (r_ff.state == SRWR_IDLE && execRise) |=> workCount == 16'h0)
    else $error("counter not cleared at start");
  a_done_wkc: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R14)
    done |-> $past(rspValid) && workCount == $past(rspWkc) && workCount != 16'h0)
    else $error("done without slave write");
  a_preempt_err: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R15)
    (busy && readStart) |=> error && errorId == `SRWR_ERR_PREEMPT)
    else $error("read did not preempt write");
  a_resp_timeout: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R09)
    (r_ff.state == SRWR_WAIT && r_ff.waitCnt == 15'(`SRWR_RESP_CYCLES - 32'h1) && !rspValid
    && !readStart) |=> error && errorId == `SRWR_ERR_NORESP) else $error("timeout missed");
  a_bcast_addr: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R02)
    (dgValid && dgCmd == `SRWR_CMD_BCAST) |-> dgAddr == 16'h0)
    else $error("broadcast address not ignored");
  // request field checks, written apart from the decode functions where possible
  a_addr_err: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R05)
    (r_ff.state == SRWR_IDLE && execRise && slavePresent && writeCommandCode == `SRWR_CMD_CONF
    && (positionAddr < `SRWR_CONF_FIRST || positionAddr > `SRWR_CONF_LAST)) |=> error
    && errorId == `SRWR_ERR_ADDR) else $error("bad address not refused");
  a_alctl_guard: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R11)
    (r_ff.state == SRWR_IDLE && execRise && regOffset == `SRWR_ALCTL_OFS
    && !(commNormal && !connBusy)) |=> error) else $error("al control written too early");
  a_start_send: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R17)
    (r_ff.state == SRWR_IDLE && execRise && slavePresent && cmdOk
    && addrOk(writeCommandCode, positionAddr) && byteLength >= `SRWR_LEN_MIN
    && byteLength <= `SRWR_LEN_MAX && !ofsProtected(regOffset, commNormal && !connBusy))
    |=> busy && dgValid) else $error("valid request not issued");
  // the datagram must not change or vanish before the network takes it
  a_dg_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R17)
    (dgValid && !dgReady && !readStart) |=> dgValid && $stable(dgCmd) && $stable(dgAddr)
    && $stable(dgOffset) && $stable(dgLength) && $stable(dgData))
    else $error("datagram dropped before taken");

endmodule

/* testbench/srwr_net_model.sv */
// ****************************************
// network of slave controllers
// ****************************************
module srwr_net_model
#(
  parameter int SLAVES = 3
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic dgValid,
  input wire logic [7:0] dgCmd,
  input wire logic [15:0] dgAddr,
  input wire logic mute,
  output logic dgReady,
  output logic rspValid,
  output logic [15:0] rspWkc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] lag; // cycles left to the answer
  logic [15:0] hits; // slaves that take this datagram
  logic [15:0] held; // counter latched at handshake
  // each slave that writes adds one to the counter
  always_comb
  begin
    hits = 16'h0000;
    if (dgCmd == 8'h08)
      hits = 16'(SLAVES);
    else if (dgCmd == 8'h02 && 16'(16'h0000 - dgAddr) < 16'(SLAVES))
      hits = 16'h0001;
    else if (dgCmd == 8'h05 && dgAddr >= 16'h03E9 && dgAddr < 16'h03E9 + 16'(SLAVES))
      hits = 16'h0001;
  end
  // ready one cycle late; a muted net never answers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dgReady <= 1'b0;
      lag <= 2'h0;
      rspValid <= 1'b0;
      rspWkc <= 16'h5A5A;
    end
    else
    begin
      dgReady <= dgValid && !dgReady;
      rspValid <= lag == 2'h1;
      // idle counter lines toggle so stale values never match
      rspWkc <= (lag == 2'h1) ? held : ~rspWkc;
      if (dgValid && dgReady)
      begin
        lag <= mute ? 2'h0 : 2'h3;
        held <= hits;
      end
      else if (lag != 2'h0)
        lag <= lag - 2'h1;
    end
  end
endmodule

/* testbench/slave_register_write_request_bench.sv */
// ****************************************
// write request bench
// ****************************************
module slave_register_write_request_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, sys_rst = 1'b1, execute = 1'b0, readStart = 1'b0;
  logic slavePresent = 1'b1, commNormal = 1'b0, connBusy = 1'b0, mute = 1'b0;
  logic regWr = 1'b0, regRd = 1'b0, busy, done, error, irq, dgValid, dgReady, rspValid;
  logic [7:0] writeCommandCode = 8'h00, dgCmd;
  logic [15:0] positionAddr = 16'h0000, regOffset = 16'h0000;
  logic [15:0] errorId, workCount, rspWkc, dgAddr, dgOffset;
  logic [2:0] byteLength = 3'h1, dgLength;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata, dgData, writeValue = 32'h0;
  int badCount = 0, comparisons = 0;
  logic [15:0] prot [14] = '{16'h0010, 16'h0011, 16'h0021, 16'h0030, 16'h0031, 16'h0040,
    16'h0103, 16'h0121, 16'h0600, 16'h06FF, 16'h0800, 16'h087F, 16'h0900, 16'h09FF};
  logic [15:0] free [6] = '{16'h0012, 16'h0041, 16'h0104, 16'h05FF, 16'h0880, 16'h0A00};

  slave_register_write_request i_slave_register_write_request (.clk_sys, .sys_rst,
    .execute, .writeCommandCode, .positionAddr, .regOffset, .byteLength,
    .writeValue, .readStart, .busy, .done, .error, .errorId, .workCount,
    .slavePresent, .commNormal, .connBusy, .dgValid, .dgReady, .dgCmd, .dgAddr,
    .dgOffset, .dgLength, .dgData, .rspValid, .rspWkc, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .irq);
  srwr_net_model #(.SLAVES(3)) i_srwr_net_model (.clk_sys, .sys_rst, .dgValid,
    .dgCmd, .dgAddr, .mute, .dgReady, .rspValid, .rspWkc);

  // 200 MHz clock
  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      badCount++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task chk32(input logic [31:0] g, input logic [31:0] e);
    chk(g[31:16], e[31:16]);
    chk(g[15:0], e[15:0]);
  endtask

  task testDone;
    if (badCount == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one request; e is the expected error code, zero for done
  task req(input logic [7:0] c, input logic [15:0] a, input logic [15:0] o,
    input logic [2:0] n, input logic [15:0] e, input logic [15:0] w);
    logic issued;
    // only a request that passed every field check reaches the network
    issued = (e == 16'h0000) || (e == 16'h0F73) || (e == 16'h1021);
    writeCommandCode <= c;
    positionAddr <= a;
    regOffset <= o;
    byteLength <= n;
    writeValue <= {o, a};
    execute <= 1'b1;
    @(posedge clk_sys);
    execute <= 1'b0;
    #1;
    chk({15'h0000, busy}, {15'h0000, issued});
    if (busy === 1'b1)
    begin
      chk(workCount, 16'h0000);
      chk({15'h0000, dgValid}, 16'h0001);
      chk({8'h00, dgCmd}, {8'h00, c});
      chk(dgAddr, (c == 8'h08) ? 16'h0000 : a);
      chk(dgOffset, o);
      chk({13'h0000, dgLength}, {13'h0000, n});
      chk32(dgData, {o, a});
    end
    // bounded wait; the no-answer timeout is the longest case
    for (int i = 0; i < 25000 && done !== 1'b1 && error !== 1'b1; i++)
      @(posedge clk_sys) #1;
    chk({15'h0000, done}, {15'h0000, e == 16'h0000});
    chk(errorId, e);
    if (e == 16'h0000)
      chk(workCount, w);
    @(posedge clk_sys);
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    #1;
  endtask

  task rd(input logic [3:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 chk32(regRdata, e);
    @(posedge clk_sys);
  endtask

  // status, mask, interrupt and an unmapped read
  task tIrq;
    req(8'h08, 16'h0000, 16'h0300, 3'h3, 16'h0000, 16'h0003);
    rd(4'h0, 32'h0000_0001);
    rd(4'h8, 32'h0000_0003);
    rd(4'hC, 32'h0000_0000);
    chk({15'h0000, irq}, 16'h0000);
    wr(4'h4, 32'h0000_0007);
    chk({15'h0000, irq}, 16'h0001);
    @(posedge clk_sys);
    rd(4'h4, 32'h0000_0007);
    wr(4'h0, 32'h0000_0001);
    chk({15'h0000, irq}, 16'h0000);
    @(posedge clk_sys);
  endtask

  // every command code from 0 to 9
  task tCodes;
    for (int k = 0; k < 10; k++)
    begin
      if (k == 2)
        req(8'h02, 16'h0000, 16'h0200, 3'h4, 16'h0000, 16'h0001);
      else if (k == 5)
        req(8'h05, 16'h03EB, 16'h0200, 3'h4, 16'h0000, 16'h0001);
      else if (k == 8)
        req(8'h08, 16'h1234, 16'h0200, 3'h4, 16'h0000, 16'h0003);
      else
        req(8'(k), 16'h0000, 16'h0200, 3'h1, 16'h0F72, 16'h0000);
    end
  endtask

  // address windows, lengths and silent slaves
  task tFields;
    slavePresent <= 1'b0;
    req(8'h08, 16'h0000, 16'h0200, 3'h1, 16'h0F09, 16'h0000);
    slavePresent <= 1'b1;
    req(8'h05, 16'h03E8, 16'h0200, 3'h2, 16'h0F70, 16'h0000);
    req(8'h05, 16'h040D, 16'h0200, 3'h2, 16'h0F70, 16'h0000);
    req(8'h02, 16'hFFDC, 16'h0200, 3'h2, 16'h0F70, 16'h0000);
    req(8'h02, 16'hFFFE, 16'h0200, 3'h1, 16'h0000, 16'h0001);
    req(8'h08, 16'h0000, 16'h0200, 3'h0, 16'h0F71, 16'h0000);
    req(8'h08, 16'h0000, 16'h0200, 3'h5, 16'h0F71, 16'h0000);
    req(8'h05, 16'h040C, 16'h0200, 3'h1, 16'h0F73, 16'h0000);
    mute <= 1'b1;
    req(8'h08, 16'h0000, 16'h0200, 3'h1, 16'h0F73, 16'h0000);
    mute <= 1'b0;
  endtask

  // protected offsets and their neighbours
  task tOfs;
    foreach (prot[k])
      req(8'h08, 16'h0000, prot[k], 3'h1, 16'h0F74, 16'h0000);
    foreach (free[k])
      req(8'h08, 16'h0000, free[k], 3'h1, 16'h0000, 16'h0003);
    req(8'h08, 16'h0000, 16'h0120, 3'h1, 16'h0F74, 16'h0000);
    commNormal <= 1'b1;
    connBusy <= 1'b1;
    req(8'h08, 16'h0000, 16'h0120, 3'h1, 16'h0F74, 16'h0000);
    connBusy <= 1'b0;
    req(8'h08, 16'h0000, 16'h0120, 3'h1, 16'h0000, 16'h0003);
  endtask

  // a read starting while the write waits wins
  task tPreempt;
    mute <= 1'b1;
    fork
      req(8'h08, 16'h0000, 16'h0200, 3'h1, 16'h1021, 16'h0000);
      begin
        repeat (5) @(posedge clk_sys);
        readStart <= 1'b1;
        @(posedge clk_sys);
        readStart <= 1'b0;
      end
    join
    mute <= 1'b0;
    // done, error and preempt events have all been latched by now
    rd(4'h0, 32'h0000_0007);
    wr(4'h0, 32'h0000_0007);
    chk({15'h0000, irq}, 16'h0000);
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    tIrq();
    tCodes();
    tFields();
    tOfs();
    tPreempt();
    testDone();
  end

  // watchdog: the run needs just over 20000 cycles
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    badCount++;
    testDone();
  end
endmodule
